// file: design/call_mode_pkg.sv
/*
  Constants and types for the call mode controller: register layout, reset
  values, vector table layout, operation codes and cycle counts.
  Assumes nothing of its surroundings; used with scoped names only.
*/
package call_mode_pkg;
  localparam int PC_W = 14;
  localparam int CNT_W = 3;

  // Stack bank select register layout
  localparam int SEL_MODE_BIT = 3;
  localparam int SEL_BANK_BIT = 0;
  localparam logic [3:0] SEL_RESET = 4'h8;

  // Program memory vector layout
  localparam logic [PC_W-1:0] VEC_RESET_ADDR = 14'h0000;
  localparam logic [PC_W-1:0] VEC_INT_BASE = 14'h0002;
  localparam logic [PC_W-1:0] VEC_INT_LAST = 14'h000d;
  localparam logic [PC_W-1:0] TABLE_FIRST = 14'h0020;
  localparam logic [PC_W-1:0] TABLE_LAST = 14'h007f;
  localparam logic [2:0] INT_COUNT = 3'h6;

  // Vector entry word: enables on top, start address below
  localparam int VEC_MEM_EN_BIT = 15;
  localparam int VEC_REG_EN_BIT = 14;

  // Stack bytes per call form
  localparam logic [1:0] STACK_LEGACY = 2'h2;
  localparam logic [1:0] STACK_EXTENDED = 2'h3;

  // Machine cycles
  localparam logic [CNT_W-1:0] CYC_CALL_ABS_LEGACY = 3'h3;
  localparam logic [CNT_W-1:0] CYC_CALL_ABS_EXT = 3'h4;
  localparam logic [CNT_W-1:0] CYC_CALL_FAST_LEGACY = 3'h2;
  localparam logic [CNT_W-1:0] CYC_CALL_FAST_EXT = 3'h3;
  localparam logic [CNT_W-1:0] CYC_LONG = 3'h3;
  localparam logic [CNT_W-1:0] CYC_RETURN = 3'h3;
  localparam logic [CNT_W-1:0] CYC_BRANCH_REG = 3'h2;
  localparam logic [CNT_W-1:0] CYC_TABLE = 3'h3;
  localparam logic [CNT_W-1:0] CYC_VECTOR = 3'h2;

  typedef enum logic [3:0] {
    OP_CALL_ABS = 4'h0,
    OP_CALL_FAST = 4'h1,
    OP_LONG_BRANCH = 4'h2,
    OP_LONG_CALL = 4'h3,
    OP_RETURN = 4'h4,
    OP_BRANCH_DE = 4'h5,
    OP_BRANCH_XA = 4'h6,
    OP_TABLE_EXEC = 4'h7
  } op_t;

  typedef enum logic [3:0] {
    ST_VEC_FETCH = 4'b0001,
    ST_VEC_LOAD = 4'b0010,
    ST_IDLE = 4'b0100,
    ST_EXEC = 4'b1000
  } state_t;
endpackage

// file: design/cycle_timer_if.sv
/*
  Handshake between the call mode controller and its machine cycle timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cycle_timer_if;
  logic start;
  logic [call_mode_pkg::CNT_W-1:0] cycles;
  logic done;
  modport ctrl (output start, output cycles, input done);
  modport timer (input start, input cycles, output done);
endinterface
`default_nettype wire

// file: design/cycle_timer.sv
/*
  Machine cycle timer: loads a cycle count on start and flags the last
  cycle of the count. Assumes start is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
  input wire logic clk_sys,
  input wire logic arst_n,
  cycle_timer_if.timer tmr
);
  logic [call_mode_pkg::CNT_W-1:0] remain;
  logic [call_mode_pkg::CNT_W-1:0] next_remain;

  always_comb begin
    next_remain = remain;
    if (tmr.start) begin
      next_remain = tmr.cycles;
    end else if (remain != '0) begin
      next_remain = remain - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  assign tmr.done = (remain == 3'h1);
endmodule
`default_nettype wire

// file: design/call_mode_ctrl.sv
/*
  Call mode controller of a 4-bit CPU core: holds the stack bank select
  register, loads reset and interrupt vectors, and works out stack usage,
  timing and targets of the call, return and branch forms per call mode.
  Assumes a synchronous program ROM with one cycle of read latency and
  request inputs driven from logic on clk_sys.
*/
//
// Contract
// - Select bit 3 picks call mode
// - Calls push 2 or 3 bytes
// - Long branch and call only extended
// - Call cycle counts depend on mode
// - Reset sets mode bit to legacy
// - Reset loads enables, start from 0000H
// - Interrupts load entry from 0002H-000DH
// - Table execute uses 0020H-007FH entries
// - Stack lives in bank 0 or 1
// - Register branches replace low PC byte
`timescale 1ns/1ps
`default_nettype none
module call_mode_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic selWrite,
  input wire logic [3:0] selWrData,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [13:0] opAddr,
  input wire logic [7:0] regPair,
  input wire logic intReq,
  input wire logic [2:0] intNum,
  input wire logic [15:0] romData,
  output logic [3:0] stackBankSelect,
  output logic legacyMode,
  output logic stackBank,
  output logic opReady,
  output logic opDone,
  output logic illegalOp,
  output logic [1:0] pushBytes,
  output logic [1:0] popBytes,
  output logic [13:0] pc,
  output logic registerBankEnable,
  output logic memoryBankEnable,
  output logic romRead,
  output logic [13:0] romAddr
);
  cycle_timer_if tmr ();

  cycle_timer timerUnit (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tmr(tmr)
  );

  function automatic logic inTable(input logic [13:0] addr);
    inTable = (addr >= call_mode_pkg::TABLE_FIRST) && (addr <= call_mode_pkg::TABLE_LAST);
  endfunction

  call_mode_pkg::state_t state;
  call_mode_pkg::state_t next_state;
  logic [3:0] next_stackBankSelect;
  logic next_opReady;
  logic next_opDone;
  logic next_illegalOp;
  logic [1:0] next_pushBytes;
  logic [1:0] next_popBytes;
  logic [13:0] next_pc;
  logic next_registerBankEnable;
  logic next_memoryBankEnable;
  logic next_romRead;
  logic [13:0] next_romAddr;
  logic start;
  logic next_start;
  logic [2:0] cycles;
  logic [2:0] next_cycles;
  logic loadVector;
  logic next_loadVector;
  logic mode;

  assign tmr.start = start;
  assign tmr.cycles = cycles;
  assign mode = stackBankSelect[call_mode_pkg::SEL_MODE_BIT];

  always_comb begin
    next_state = state;
    next_stackBankSelect = stackBankSelect;
    next_opDone = 1'b0;
    next_illegalOp = 1'b0;
    next_pushBytes = pushBytes;
    next_popBytes = popBytes;
    next_pc = pc;
    next_registerBankEnable = registerBankEnable;
    next_memoryBankEnable = memoryBankEnable;
    next_romRead = 1'b0;
    next_romAddr = romAddr;
    next_start = 1'b0;
    next_cycles = cycles;
    next_loadVector = loadVector;
    // A plain 4-bit store; software picks 100x or 000x at program start
    if (selWrite) begin
      next_stackBankSelect = selWrData;
    end
    case (state)
      call_mode_pkg::ST_VEC_FETCH: begin
        next_state = call_mode_pkg::ST_VEC_LOAD;
      end
      call_mode_pkg::ST_VEC_LOAD: begin
        // Entry word carries both enables and the start address
        next_memoryBankEnable = romData[call_mode_pkg::VEC_MEM_EN_BIT];
        next_registerBankEnable = romData[call_mode_pkg::VEC_REG_EN_BIT];
        next_pc = romData[13:0];
        next_state = call_mode_pkg::ST_IDLE;
        next_opDone = loadVector;
        next_loadVector = 1'b0;
      end
      call_mode_pkg::ST_IDLE: begin
        // Interrupts numbered 0 to 5 win over a pending instruction
        if (intReq && (intNum < call_mode_pkg::INT_COUNT)) begin
          next_romAddr = call_mode_pkg::VEC_INT_BASE + {10'h000, intNum, 1'b0};
          next_romRead = 1'b1;
          next_loadVector = 1'b1;
          next_state = call_mode_pkg::ST_VEC_FETCH;
        end else if (opValid) begin
          next_state = call_mode_pkg::ST_EXEC;
          next_start = 1'b1;
          next_pushBytes = 2'h0;
          next_popBytes = 2'h0;
          case (opCode)
            call_mode_pkg::OP_CALL_ABS: begin
              next_pc = opAddr;
              next_pushBytes = mode ? call_mode_pkg::STACK_LEGACY
                                    : call_mode_pkg::STACK_EXTENDED;
              next_cycles = mode ? call_mode_pkg::CYC_CALL_ABS_LEGACY
                                 : call_mode_pkg::CYC_CALL_ABS_EXT;
            end
            call_mode_pkg::OP_CALL_FAST: begin
              next_pc = opAddr;
              next_pushBytes = mode ? call_mode_pkg::STACK_LEGACY
                                    : call_mode_pkg::STACK_EXTENDED;
              next_cycles = mode ? call_mode_pkg::CYC_CALL_FAST_LEGACY
                                 : call_mode_pkg::CYC_CALL_FAST_EXT;
            end
            call_mode_pkg::OP_LONG_BRANCH, call_mode_pkg::OP_LONG_CALL: begin
              // Legacy mode has no long forms: refuse, keep PC and stack
              if (mode) begin
                next_illegalOp = 1'b1;
                next_start = 1'b0;
                next_state = call_mode_pkg::ST_IDLE;
              end else begin
                next_pc = opAddr;
                next_cycles = call_mode_pkg::CYC_LONG;
                if (opCode == call_mode_pkg::OP_LONG_CALL) begin
                  next_pushBytes = call_mode_pkg::STACK_EXTENDED;
                end
              end
            end
            call_mode_pkg::OP_RETURN: begin
              // Balance only holds if the mode did not change inside a call
              next_pc = opAddr;
              next_popBytes = mode ? call_mode_pkg::STACK_LEGACY
                                   : call_mode_pkg::STACK_EXTENDED;
              next_cycles = call_mode_pkg::CYC_RETURN;
            end
            call_mode_pkg::OP_BRANCH_DE, call_mode_pkg::OP_BRANCH_XA: begin
              next_pc = {pc[13:8], regPair};
              next_cycles = call_mode_pkg::CYC_BRANCH_REG;
            end
            call_mode_pkg::OP_TABLE_EXEC: begin
              if (inTable(opAddr)) begin
                next_romAddr = opAddr;
                next_romRead = 1'b1;
                next_cycles = call_mode_pkg::CYC_TABLE;
              end else begin
                next_illegalOp = 1'b1;
                next_start = 1'b0;
                next_state = call_mode_pkg::ST_IDLE;
              end
            end
            default: begin
              next_illegalOp = 1'b1;
              next_start = 1'b0;
              next_state = call_mode_pkg::ST_IDLE;
            end
          endcase
        end
      end
      call_mode_pkg::ST_EXEC: begin
        if (tmr.done) begin
          next_state = call_mode_pkg::ST_IDLE;
          next_opDone = 1'b1;
        end
      end
      default: begin
        next_state = call_mode_pkg::ST_IDLE;
      end
    endcase
    next_opReady = (next_state == call_mode_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Reset begins with the reset vector read already on the ROM port
      state <= call_mode_pkg::ST_VEC_FETCH;
      stackBankSelect <= call_mode_pkg::SEL_RESET;
      opReady <= 1'b0;
      opDone <= 1'b0;
      illegalOp <= 1'b0;
      pushBytes <= 2'h0;
      popBytes <= 2'h0;
      pc <= '0;
      registerBankEnable <= 1'b0;
      memoryBankEnable <= 1'b0;
      romRead <= 1'b1;
      romAddr <= call_mode_pkg::VEC_RESET_ADDR;
      start <= 1'b0;
      cycles <= '0;
      loadVector <= 1'b0;
    end else begin
      state <= next_state;
      stackBankSelect <= next_stackBankSelect;
      opReady <= next_opReady;
      opDone <= next_opDone;
      illegalOp <= next_illegalOp;
      pushBytes <= next_pushBytes;
      popBytes <= next_popBytes;
      pc <= next_pc;
      registerBankEnable <= next_registerBankEnable;
      memoryBankEnable <= next_memoryBankEnable;
      romRead <= next_romRead;
      romAddr <= next_romAddr;
      start <= next_start;
      cycles <= next_cycles;
      loadVector <= next_loadVector;
    end
  end

  // Mirrors of the select register so outputs stay flop-driven
  logic next_legacyMode;
  logic next_stackBank;
  always_comb begin
    next_legacyMode = next_stackBankSelect[call_mode_pkg::SEL_MODE_BIT];
    next_stackBank = next_stackBankSelect[call_mode_pkg::SEL_BANK_BIT];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      legacyMode <= call_mode_pkg::SEL_RESET[call_mode_pkg::SEL_MODE_BIT];
      stackBank <= call_mode_pkg::SEL_RESET[call_mode_pkg::SEL_BANK_BIT];
    end else begin
      legacyMode <= next_legacyMode;
      stackBank <= next_stackBank;
    end
  end
endmodule
`default_nettype wire

// file: testbench/call_mode_ctrl_assertions.sv
/*
  Port checker for call_mode_ctrl.
  Assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module call_mode_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [13:0] opAddr,
  input wire logic [7:0] regPair,
  input wire logic intReq,
  input wire logic [2:0] intNum,
  input wire logic [3:0] stackBankSelect,
  input wire logic legacyMode,
  input wire logic stackBank,
  input wire logic opReady,
  input wire logic opDone,
  input wire logic illegalOp,
  input wire logic [1:0] pushBytes,
  input wire logic [1:0] popBytes,
  input wire logic [13:0] pc,
  input wire logic romRead,
  input wire logic [13:0] romAddr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic take;
  // A pending interrupt numbered below 6 wins over a request in the same cycle
  assign take = opReady && opValid && !(intReq && intNum < 3'h6);

  a_mode_follow: assert property (legacyMode == stackBankSelect[3])
    else $error("call mode does not follow select bit");
  a_bank_follow: assert property (stackBank == stackBankSelect[0])
    else $error("stack bank does not follow select bit");
  a_push_count: assert property (take && opCode inside {4'h0, 4'h1} |=>
    pushBytes == ($past(legacyMode) ? 2'h2 : 2'h3)) else $error("call push count wrong");
  a_long_refused: assert property (take && legacyMode && opCode inside {4'h2, 4'h3} |=>
    illegalOp && opReady && !opDone) else $error("long form ran in legacy mode");
  a_abs_legacy: assert property (take && opCode == 4'h0 && legacyMode |=>
    !opDone [*4] ##1 opDone) else $error("legacy absolute call timing wrong");
  a_abs_ext: assert property (take && opCode == 4'h0 && !legacyMode |=>
    !opDone [*5] ##1 opDone) else $error("extended absolute call timing wrong");
  a_fast_legacy: assert property (take && opCode == 4'h1 && legacyMode |=>
    !opDone [*3] ##1 opDone) else $error("legacy fast call timing wrong");
  a_vector_addr: assert property (opReady && intReq && intNum < 3'h6 |=>
    romRead && romAddr == 14'h0002 + {10'h000, $past(intNum), 1'b0})
    else $error("interrupt vector address wrong");
  a_table_range: assert property (take && opCode == 4'h7 &&
    (opAddr < 14'h0020 || opAddr > 14'h007f) |=> illegalOp) else $error("table entry out of range");
  a_low_branch: assert property (take && opCode inside {4'h5, 4'h6} |=>
    pc == {$past(pc[13:8]), $past(regPair)}) else $error("register branch target wrong");
  a_pop_match: assert property (take && opCode == 4'h4 |=>
    popBytes == ($past(legacyMode) ? 2'h2 : 2'h3)) else $error("return pop count wrong");
endmodule

bind call_mode_ctrl call_mode_ctrl_assertions u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .regPair(regPair), .intReq(intReq),
  .intNum(intNum), .stackBankSelect(stackBankSelect), .legacyMode(legacyMode),
  .stackBank(stackBank), .opReady(opReady), .opDone(opDone), .illegalOp(illegalOp),
  .pushBytes(pushBytes), .popBytes(popBytes), .pc(pc), .romRead(romRead), .romAddr(romAddr));
`default_nettype wire

// file: testbench/call_mode_ctrl_bench.sv
/*
  Self-checking bench for call_mode_ctrl with a small vector ROM.
  Assumes the package, design and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module call_mode_ctrl_bench;
  logic clk_sys, arst_n, selWrite, opValid, intReq, legacyMode, stackBank;
  logic opReady, opDone, illegalOp, romRead, regBankEn, memBankEn;
  logic [3:0] selWrData, opCode, stackBankSelect;
  logic [13:0] opAddr, pc, romAddr;
  logic [7:0] regPair;
  logic [2:0] intNum;
  logic [15:0] romData;
  logic [1:0] pushBytes, popBytes;
  int n_mismatch = 0;
  int n_compared = 0;

  call_mode_ctrl u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .selWrite(selWrite),
    .selWrData(selWrData), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
    .regPair(regPair), .intReq(intReq), .intNum(intNum), .romData(romData),
    .stackBankSelect(stackBankSelect), .legacyMode(legacyMode), .stackBank(stackBank),
    .opReady(opReady), .opDone(opDone), .illegalOp(illegalOp), .pushBytes(pushBytes),
    .popBytes(popBytes), .pc(pc), .registerBankEnable(regBankEn), .memoryBankEnable(memBankEn),
    .romRead(romRead), .romAddr(romAddr));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Word: enable on top, enable from address bit 1, start 0100H plus address
  always @(posedge clk_sys) romData <= {1'b1, romAddr[1], 14'h0100 + romAddr};

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic waitDone(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 20) begin
        n_mismatch++;
        summarize();
      end
    end while (opDone !== 1'b1);
  endtask

  // cyc of 0 means the request must be refused
  task automatic op(input logic [3:0] c, input logic [13:0] a, input logic [1:0] pu,
      input logic [1:0] po, input int cyc);
    int n;
    @(posedge clk_sys);
    opCode <= c;
    opAddr <= a;
    opValid <= 1'b1;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    if (cyc == 0) begin
      chk({illegalOp, opReady}, 2'h3);
    end else begin
      if (c == 4'h7) chk({romRead, romAddr, pushBytes, popBytes}, {1'b1, a, pu, po});
      else chk({pc, pushBytes, popBytes}, {a, pu, po});
      waitDone(n);
      chk(n, cyc + 1);
    end
  endtask

  task automatic writeSelect(input logic [3:0] v);
    @(posedge clk_sys);
    selWrite <= 1'b1;
    selWrData <= v;
    @(posedge clk_sys);
    selWrite <= 1'b0;
    @(posedge clk_sys);
    #1 chk({stackBankSelect, legacyMode, stackBank}, {v, v[3], v[0]});
  endtask

  task automatic tReset;
    int n;
    chk({romRead, romAddr}, 15'h4000);
    // Released on the twelfth edge; outputs are read 1 ns after each edge
    arst_n <= 1'b1;
    for (n = 0; n < 10 && opReady !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (opReady !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    chk({stackBankSelect, legacyMode, memBankEn, regBankEn, pc}, {4'h8, 3'h6, 14'h0100});
    $display("reset test done");
  endtask

  task automatic tLegacy;
    op(4'h0, 14'h0345, 2'h2, 2'h0, 3);
    op(4'h1, 14'h0456, 2'h2, 2'h0, 2);
    op(4'h4, 14'h0567, 2'h0, 2'h2, 3);
    op(4'h2, 14'h0678, 2'h0, 2'h0, 0);
    op(4'h3, 14'h0789, 2'h0, 2'h0, 0);
    $display("legacy test done");
  endtask

  task automatic tExtended;
    writeSelect(4'h1);
    op(4'h0, 14'h1234, 2'h3, 2'h0, 4);
    op(4'h1, 14'h0456, 2'h3, 2'h0, 3);
    op(4'h3, 14'h2a00, 2'h3, 2'h0, 3);
    op(4'h2, 14'h2a55, 2'h0, 2'h0, 3);
    regPair <= 8'h3c;
    op(4'h5, 14'h2a3c, 2'h0, 2'h0, 2);
    regPair <= 8'hc3;
    op(4'h6, 14'h2ac3, 2'h0, 2'h0, 2);
    op(4'h4, 14'h0567, 2'h0, 2'h3, 3);
    $display("extended test done");
  endtask

  task automatic tTable;
    op(4'h7, 14'h0020, 2'h0, 2'h0, 3);
    op(4'h7, 14'h007f, 2'h0, 2'h0, 3);
    op(4'h7, 14'h0080, 2'h0, 2'h0, 0);
    op(4'h7, 14'h001f, 2'h0, 2'h0, 0);
    $display("table test done");
  endtask

  task automatic tVectors;
    int n;
    logic [13:0] v;
    for (int k = 0; k < 6; k++) begin
      v = 14'h0002 + 14'(2 * k);
      @(posedge clk_sys);
      intNum <= 3'(k);
      intReq <= 1'b1;
      @(posedge clk_sys);
      intReq <= 1'b0;
      #1 chk({romRead, romAddr}, {1'b1, v});
      waitDone(n);
      chk({memBankEn, regBankEn, pc}, {1'b1, v[1], 14'h0100 + v});
    end
    writeSelect(4'h9);
    // An interrupt number past the table must not steal the request
    intNum <= 3'h7;
    intReq <= 1'b1;
    op(4'h4, 14'h0123, 2'h0, 2'h2, 3);
    intReq <= 1'b0;
    $display("vector test done");
  endtask

  initial begin
    arst_n = 1'b0;
    selWrite = 1'b0;
    selWrData = 4'h0;
    opValid = 1'b0;
    opCode = 4'h0;
    opAddr = 14'h0000;
    regPair = 8'h00;
    intReq = 1'b0;
    intNum = 3'h0;
    repeat (12) @(posedge clk_sys);
    tReset();
    tLegacy();
    tExtended();
    tTable();
    tVectors();
    summarize();
  end
endmodule
`default_nettype wire
